// >>> src/dma_channel.sv
// Single DMA channel: configuration registers, request handling and burst sequencing.
//
// Overview of operation
// R1: Software picks widths and count so the source bits total a whole number of destination items.
// R2: In peripheral flows a raised request line starts a burst of data transfer.
// R3: Memory-to-memory transfers start only from a software trigger write.
// R4: Each accepted request moves at most one programmed burst of items; with bit 16 set, the bursts chain to the end of the count.
// R5: Burst data pass through a sixteen-word channel FIFO.
// R6: Reset clears every defined configuration field to zero.
// R7: Configuration bit 18 set makes the channel ignore incoming requests.
// R8: Read-only configuration bit 17 shows whether the FIFO holds data.
// R9: Configuration bit 16 keeps the bus held across all bursts back to back.
// R10: Configuration bit 15 gates the transfer-completion interrupt output.
`timescale 1ns/1ps
module dma_channel
   import dma_chan_pkg::*;
(
   input  wire logic              clk_sys_i,
   input  wire logic              rst_n_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic [DATA_W-1:0]      rdata_o,
   input  wire logic [15:0]       dma_req_i,
   input  wire logic [DATA_W-1:0] src_data_i,
   output logic                   src_read_o,
   output logic [DATA_W-1:0]      dst_data_o,
   output logic                   dst_write_o,
   input  wire logic              dst_ready_i,
   output logic                   bus_lock_o,
   output logic                   done_irq_o,
   output logic                   fault_irq_o
);
   // ****************************************
   // Register file
   // ****************************************
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_BURST = 3'b010,
      ST_DRAIN = 3'b100
   } state_t;
   state_t      state_reg;
   state_t      state_next;
   logic [31:0] cfg_reg;
   logic [31:0] ctl_reg;
   logic [11:0] left_reg;
   logic [8:0]  beat_reg;
   logic        sw_start_reg;
   logic [31:0] rdata_reg;
   logic        src_read_reg;
   logic        bus_lock_reg;
   logic        done_irq_reg;
   logic        fault_irq_reg;
   logic        fifo_busy;
   logic        fifo_in_ready;
   logic        fifo_out_valid;
   logic [31:0] fifo_out_data;
   logic        dst_write_reg;
   logic [31:0] dst_data_reg;
   // ****************************************
   // Field decode
   // ****************************************
   wire         wr_cfg    = wr_i && (addr_i == OFF_CONFIG);
   wire         wr_ctl    = wr_i && (addr_i == OFF_CONTROL);
   wire         wr_trig   = wr_i && (addr_i == OFF_TRIGGER);
   wire         enabled   = cfg_reg[CFG_ENABLE];
   wire [2:0]   flow      = cfg_reg[CFG_FLOW_LSB +: 3];
   wire [3:0]   src_num   = cfg_reg[CFG_SRC_LSB +: 4];
   wire [3:0]   dst_num   = cfg_reg[CFG_DST_LSB +: 4];
   wire [2:0]   sburst    = ctl_reg[CTL_SBURST_LSB +: 3];
   wire [2:0]   swidth    = ctl_reg[CTL_SWIDTH_LSB +: 3];
   wire [2:0]   dwidth    = ctl_reg[CTL_DWIDTH_LSB +: 3];
   wire [11:0]  count     = ctl_reg[CTL_COUNT_LSB +: 12];
   // Burst codes 0 and 1..7 map to 1, then 4 doubling up to 256 beats.
   wire [8:0]   burst_len = (sburst == 3'h0) ? 9'h001 : 9'(9'h002 << sburst);
   // R1 setting check
   wire [14:0]  src_bits  = 15'(count) << swidth;
   wire         bad_set   = (dwidth > swidth) &&
                            ((src_bits & ~(15'h7FFF << dwidth)) != 15'h0000);
   // R7 halt gating
   wire         req_ok    = !cfg_reg[CFG_HALT] && enabled;
   // R2 request select
   wire         periph_req = (flow == FLOW_P2M) ? dma_req_i[src_num] :
                             (flow == FLOW_M2P) ? dma_req_i[dst_num] : 1'b0;
   // R3 software start
   wire         m2m_go    = (flow == FLOW_M2M) && sw_start_reg;
   wire         go        = req_ok && (periph_req || m2m_go) && (left_reg != 12'h000);
   // A beat waits until the previous word has landed in the FIFO, so the room it sees is
   // never stale; the price is one source read every other cycle.
   wire         beat      = (state_reg == ST_BURST) && fifo_in_ready && !src_read_reg;
   wire         last_beat = beat && ((beat_reg == 9'h001) || (left_reg == 12'h001));
   wire [31:0]  status_w  = {19'h00000, 1'b0, 12'(left_reg)};
   // The last word read is still on its way into the FIFO for one cycle after the burst.
   wire         drained   = !fifo_busy && !src_read_reg;
   // R10 completion interrupt gate
   wire         done_now  = cfg_reg[CFG_DONE_IE] && (state_reg == ST_DRAIN) && drained &&
                            (left_reg == 12'h000);
   wire         fault_now = cfg_reg[CFG_FAULT_IE] && enabled && bad_set;
   wire [31:0]  rd_mux    = (addr_i == OFF_CONFIG)  ? cfg_reg :
                            (addr_i == OFF_CONTROL) ? ctl_reg :
                            (addr_i == OFF_STATUS)  ? status_w : 32'h0000_0000;
   // ****************************************
   // Sequencer
   // ****************************************
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (go) begin
               state_next = ST_BURST;
            end
         end
         ST_BURST: begin
            // R9 locked bursts chain
            if (last_beat && cfg_reg[CFG_LOCK] && (left_reg != 12'h001) && req_ok) begin
               state_next = ST_BURST;
            end else if (last_beat) begin
               state_next = ST_DRAIN;
            end
         end
         // Drain ends once the last word has left, so the done pulse never runs ahead of data.
         ST_DRAIN: begin
            if (drained) begin
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end
   // ****************************************
   // Configuration and control registers
   // ****************************************
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         // R6 reset clears
         cfg_reg <= CFG_RESET;
         ctl_reg <= CTL_RESET;
      end else begin
         if (wr_cfg) begin
            cfg_reg <= (wdata_i & CFG_WMASK) | (cfg_reg & ~CFG_WMASK);
         end else begin
            // R8 FIFO occupied flag
            cfg_reg[CFG_ACTIVE] <= fifo_busy;
         end
         if (wr_ctl) begin
            ctl_reg <= wdata_i & CTL_WMASK;
         end
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg    <= ST_IDLE;
         left_reg     <= 12'h000;
         beat_reg     <= 9'h000;
         sw_start_reg <= 1'b0;
      end else begin
         state_reg    <= state_next;
         // A trigger written while the channel is busy stays pending for the next start.
         sw_start_reg <= (sw_start_reg || wr_trig) && !(state_reg == ST_IDLE && go);
         if (wr_ctl) begin
            left_reg <= wdata_i[CTL_COUNT_LSB +: 12];
         end else if (beat) begin
            left_reg <= left_reg - 12'h001;
         end
         // R4 burst length load
         if (state_reg == ST_IDLE || (last_beat && state_next == ST_BURST)) begin
            beat_reg <= burst_len;
         end else if (beat) begin
            beat_reg <= beat_reg - 9'h001;
         end
      end
   end
   // ****************************************
   // Outputs
   // ****************************************
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_reg     <= 32'h0000_0000;
         src_read_reg  <= 1'b0;
         bus_lock_reg  <= 1'b0;
         done_irq_reg  <= 1'b0;
         fault_irq_reg <= 1'b0;
      end else begin
         rdata_reg     <= rd_i ? rd_mux : 32'h0000_0000;
         src_read_reg  <= beat;
         bus_lock_reg  <= (state_next == ST_BURST) && cfg_reg[CFG_LOCK];
         done_irq_reg  <= done_now;
         fault_irq_reg <= fault_now;
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dst_write_reg <= 1'b0;
         dst_data_reg  <= 32'h0000_0000;
      end else begin
         dst_write_reg <= fifo_out_valid && dst_ready_i;
         dst_data_reg  <= fifo_out_data;
      end
   end
   assign rdata_o     = rdata_reg;
   assign src_read_o  = src_read_reg;
   assign bus_lock_o  = bus_lock_reg;
   assign done_irq_o  = done_irq_reg;
   assign fault_irq_o = fault_irq_reg;
   assign dst_write_o = dst_write_reg;
   assign dst_data_o  = dst_data_reg;
   // ****************************************
   // Channel FIFO
   // ****************************************
   // R5 staging FIFO
   dma_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_fifo (
      .clk_sys_i   (clk_sys_i),
      .rst_n_i     (rst_n_i),
      .in_data_i   (src_data_i),
      .in_valid_i  (src_read_reg),
      .in_ready_o  (fifo_in_ready),
      .out_data_o  (fifo_out_data),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (dst_ready_i),
      .busy_o      (fifo_busy)
   );
endmodule

// >>> include/dma_chan_pkg.sv
// Package with register map and field layout for the DMA channel.
package dma_chan_pkg;
   localparam int          ADDR_W          = 4;
   localparam int          DATA_W          = 32;
   localparam int          FIFO_DEPTH      = 16;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [3:0]  OFF_CONFIG      = 4'h0;
   localparam logic [3:0]  OFF_CONTROL     = 4'h4;
   localparam logic [3:0]  OFF_TRIGGER     = 4'h8;
   localparam logic [3:0]  OFF_STATUS      = 4'hC;
   // ****************************************
   // Configuration fields
   // ****************************************
   localparam int          CFG_ENABLE      = 0;
   localparam int          CFG_SRC_LSB     = 1;
   localparam int          CFG_DST_LSB     = 6;
   localparam int          CFG_FLOW_LSB    = 11;
   localparam int          CFG_FAULT_IE    = 14;
   localparam int          CFG_DONE_IE     = 15;
   localparam int          CFG_LOCK        = 16;
   localparam int          CFG_ACTIVE      = 17;
   localparam int          CFG_HALT        = 18;
   localparam logic [31:0] CFG_WMASK       = 32'h0005_FBDF;
   localparam logic [31:0] CFG_RESET       = 32'h0000_0000;
   // ****************************************
   // Control fields
   // ****************************************
   localparam int          CTL_COUNT_LSB   = 0;
   localparam int          CTL_SBURST_LSB  = 12;
   localparam int          CTL_SWIDTH_LSB  = 18;
   localparam int          CTL_DWIDTH_LSB  = 21;
   localparam logic [31:0] CTL_WMASK       = 32'h00FC_7FFF;
   localparam logic [31:0] CTL_RESET       = 32'h0000_0000;
   localparam logic [2:0]  FLOW_M2M        = 3'h0;
   localparam logic [2:0]  FLOW_M2P        = 3'h1;
   localparam logic [2:0]  FLOW_P2M        = 3'h2;
endpackage

// >>> src/dma_fifo.sv
// Parameterised channel FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module dma_fifo #(
   parameter int W = 32,
   parameter int D = 16
) (
   input  wire logic         clk_sys_i,
   input  wire logic         rst_n_i,
   input  wire logic [W-1:0] in_data_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   output logic [W-1:0]      out_data_o,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic              busy_o
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem_reg [D];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0]   cnt_reg;
   wire           full  = (cnt_reg == (AW+1)'(D));
   wire           empty = (cnt_reg == '0);
   wire           push  = in_valid_i && !full;
   wire           pop   = out_valid_o && out_ready_i;
   assign in_ready_o  = !full;
   assign out_valid_o = !empty;
   assign out_data_o  = mem_reg[rd_ptr_reg];
   assign busy_o      = !empty;
   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data_i;
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         cnt_reg    <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// >>> test/dma_channel_chk.sv
// Port checker for the DMA channel.
`timescale 1ns/1ps
module dma_channel_chk
   import dma_chan_pkg::*;
(
   input wire logic              clk_sys_i,
   input wire logic              rst_n_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic              wr_i,
   input wire logic              rd_i,
   input wire logic [DATA_W-1:0] rdata_o,
   input wire logic              dst_write_o,
   input wire logic              dst_ready_i,
   input wire logic              bus_lock_o,
   input wire logic              done_irq_o,
   input wire logic              fault_irq_o
);
   logic [31:0] cfg_reg;
   // Shadow of the writable configuration bits.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) cfg_reg <= CFG_RESET;
      else if (wr_i && addr_i == OFF_CONFIG) cfg_reg <= wdata_i & CFG_WMASK;
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   property p_rd_idle; !$past(rd_i) |-> rdata_o == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
   property p_cfg_rd; rd_i && addr_i == OFF_CONFIG |=> (rdata_o & 32'hFFFD_FFFF) == $past(cfg_reg);
   endproperty
   a_cfg_rd: assert property (p_cfg_rd) else $error("config readback wrong");
   property p_pop; dst_write_o |-> $past(dst_ready_i); endproperty
   a_pop: assert property (p_pop) else $error("pop without ready");
   property p_lock; !cfg_reg[CFG_LOCK] && !$past(cfg_reg[CFG_LOCK]) |-> !bus_lock_o; endproperty
   a_lock: assert property (p_lock) else $error("lock without bit");
   property p_done; !cfg_reg[CFG_DONE_IE] && !$past(cfg_reg[CFG_DONE_IE]) |-> !done_irq_o;
   endproperty
   a_done: assert property (p_done) else $error("done irq while gated");
   property p_fault; !cfg_reg[CFG_FAULT_IE] && !$past(cfg_reg[CFG_FAULT_IE]) |-> !fault_irq_o;
   endproperty
   a_fault: assert property (p_fault) else $error("fault irq while gated");
   property p_done_pulse; done_irq_o |=> !done_irq_o; endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done irq too long");
   property p_fault_cause; $rose(fault_irq_o) |-> $past(wr_i) || $past(wr_i, 2) || $past(wr_i, 3);
   endproperty
   a_fault_cause: assert property (p_fault_cause) else $error("fault with no setup");
   c_pop: cover property (dst_write_o);
   c_done: cover property (done_irq_o);
   c_lock: cover property (bus_lock_o);
   c_fault: cover property (fault_irq_o);
endmodule
bind dma_channel dma_channel_chk u_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .dst_write_o(dst_write_o), .dst_ready_i(dst_ready_i), .bus_lock_o(bus_lock_o),
   .done_irq_o(done_irq_o), .fault_irq_o(fault_irq_o));

// >>> test/periph_model.sv
// Peripheral model: request line and source data.
`timescale 1ns/1ps
module periph_model (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   input  wire logic        want_i,
   input  wire logic [3:0]  num_i,
   input  wire logic        src_read_i,
   output logic [15:0]      dma_req_o,
   output logic [31:0]      src_data_o
);
   logic        served_reg;
   logic [15:0] cnt_reg;
   wire  [31:0] word = {16'hD000, cnt_reg + 16'h0001};
   assign dma_req_o  = (want_i && !served_reg) ? 16'h0001 << num_i : 16'h0000;
   // Data is true only while the read strobe stands, so early or late sampling shows up.
   assign src_data_o = src_read_i ? word : ~word;
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         served_reg <= 1'b0;
         cnt_reg    <= 16'h0;
      end else begin
         served_reg <= want_i && (served_reg || src_read_i);
         cnt_reg    <= cnt_reg + 16'(src_read_i);
      end
   end
endmodule

// >>> test/test_dma_channel.sv
// Self-checking bench for the DMA channel.
`timescale 1ns/1ps
module test_dma_channel;
   import dma_chan_pkg::*;
   logic        clk_sys_i, rst_n_i, wr_i, rd_i, dst_ready_i, want;
   logic [3:0]  addr_i, num;
   logic [31:0] wdata_i, rdata_o, src_data_i, dst_data_o, d, nxt;
   logic [15:0] dma_req_i;
   logic        src_read_o, dst_write_o, bus_lock_o, done_irq_o, fault_irq_o;
   int          bad_count, check_count, n_src, n_dst, n_done, n_lock;
   dma_channel DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .dma_req_i(dma_req_i),
      .src_data_i(src_data_i), .src_read_o(src_read_o), .dst_data_o(dst_data_o),
      .dst_write_o(dst_write_o), .dst_ready_i(dst_ready_i), .bus_lock_o(bus_lock_o),
      .done_irq_o(done_irq_o), .fault_irq_o(fault_irq_o));
   periph_model u_per (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .want_i(want), .num_i(num),
      .src_read_i(src_read_o), .dma_req_o(dma_req_i), .src_data_o(src_data_i));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk_sys_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask
   task rd(input logic [3:0] a);
      @(posedge clk_sys_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      @(negedge clk_sys_i);
      d = rdata_o;
      @(posedge clk_sys_i);
   endtask
   // Counts pulses at mid-cycle over a fixed window and checks each popped word in order.
   // It ends on a rising edge so that the next drive lands there.
   task run(input int n);
      n_src = 0;
      n_dst = 0;
      n_done = 0;
      n_lock = 0;
      repeat (n) begin
         @(negedge clk_sys_i);
         n_src += int'(src_read_o);
         n_done += int'(done_irq_o);
         n_lock += int'(bus_lock_o);
         if (dst_write_o === 1'b1) begin
            n_dst++;
            chk(dst_data_o, nxt);
            nxt++;
         end
      end
      @(posedge clk_sys_i);
   endtask
   task t_reset;
      rd(OFF_CONFIG);
      chk(d, 32'h0000_0000);
      rd(4'h2);
      chk(d, 32'h0000_0000);
      $display("reset test done");
   endtask
   task t_halt;
      wr(OFF_CONTROL, 32'h0048_1008);
      wr(OFF_CONFIG, 32'h0004_1007);
      want <= 1'b1;
      run(20);
      chk(n_src, 0);
      want <= 1'b0;
      $display("halt test done");
   endtask
   task t_burst;
      dst_ready_i <= 1'b0;
      wr(OFF_CONFIG, 32'h0000_9007);
      want <= 1'b1;
      run(20);
      chk(n_src, 4);
      rd(OFF_CONFIG);
      chk(d, 32'h0002_9007);
      dst_ready_i <= 1'b1;
      run(20);
      chk(n_dst, 4);
      rd(OFF_CONFIG);
      chk(d, 32'h0000_9007);
      rd(OFF_STATUS);
      chk(d, 32'h0000_0004);
      want <= 1'b0;
      run(3);
      want <= 1'b1;
      run(30);
      chk(n_src, 4);
      chk(n_done, 1);
      $display("burst test done");
   endtask
   task t_lock;
      want <= 1'b0;
      wr(OFF_CONTROL, 32'h0048_1008);
      wr(OFF_CONFIG, 32'h0001_9007);
      want <= 1'b1;
      run(40);
      chk(n_src, 8);
      chk(n_lock != 0, 1);
      want <= 1'b0;
      $display("lock test done");
   endtask
   task t_m2m;
      num <= 4'h0;
      wr(OFF_CONTROL, 32'h0048_1008);
      wr(OFF_CONFIG, 32'h0000_0001);
      want <= 1'b1;
      run(20);
      chk(n_src, 0);
      wr(OFF_TRIGGER, 32'h0000_0000);
      run(40);
      chk(n_src != 0, 1);
      $display("memory test done");
   endtask
   task t_m2p;
      want <= 1'b0;
      num <= 4'h3;
      wr(OFF_CONTROL, 32'h0048_1008);
      wr(OFF_CONFIG, 32'h0000_08C1);
      want <= 1'b1;
      run(20);
      chk(n_src, 4);
      want <= 1'b0;
      $display("peripheral write test done");
   endtask
   task t_fault;
      wr(OFF_CONTROL, 32'h0040_0019);
      wr(OFF_CONFIG, 32'h0000_4001);
      run(4);
      chk(fault_irq_o, 1);
      wr(OFF_CONTROL, 32'h0028_000D);
      run(4);
      chk(fault_irq_o, 0);
      $display("fault test done");
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      clk_sys_i = 1'b0;
      forever #25 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      {rst_n_i, wr_i, rd_i, dst_ready_i, want} = 5'h0;
      {addr_i, num, wdata_i} = {4'h0, 4'h3, 32'h0};
      nxt = 32'hD000_0001;
      repeat (20) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_halt();
      t_burst();
      t_lock();
      t_m2m();
      t_m2p();
      t_fault();
      test_done();
   end
endmodule
